// ===== verilog/rspb_defines.vh
/*
  constants of the regulator setpoint bank: register offsets, field
  positions, reset value, mode codes and level-to-millivolt scaling.
  assumes an 8-bit register port with 9-bit byte offsets.
*/
`ifndef RSPB_DEFINES_VH
`define RSPB_DEFINES_VH

`define RSPB_ADDR_W         9
`define RSPB_OFF_SD3_A      9'h0A7
`define RSPB_OFF_LR1_A      9'h0A9
`define RSPB_OFF_LR2_A      9'h0AA
`define RSPB_OFF_LR3_A      9'h0AB
`define RSPB_OFF_LR4_A      9'h0AC
`define RSPB_OFF_SD2_B      9'h0B4
`define RSPB_OFF_SD1_B      9'h0B5
`define RSPB_OFF_SD4_B      9'h0B6
`define RSPB_OFF_SD3_B      9'h0B8
`define RSPB_OFF_LR1_B      9'h0BA
`define RSPB_OFF_LR2_B      9'h0BB
`define RSPB_OFF_LR3_B      9'h0BC

`define RSPB_REG_RESET      8'h00
`define RSPB_RDATA_UNMAPPED 8'h00

`define RSPB_SLEEP_BIT      7
`define RSPB_SD_LVL_MSB     6
`define RSPB_LR_LVL_MSB     5

`define RSPB_MODE_BY_SEL    2'h0
`define RSPB_MODE_PFM       2'h1
`define RSPB_MODE_PWM       2'h2
`define RSPB_MODE_AUTO      2'h3

`define RSPB_LR_CODE_MIN    6'h02
`define RSPB_LR_CODE_MAX    6'h38

`define RSPB_SD12_BASE_MV   12'd300
`define RSPB_SD12_STEP_MV   12'd10
`define RSPB_SD3_BASE_MV    12'd800
`define RSPB_SD3_STEP_MV    12'd20
`define RSPB_SD4_BASE_MV    12'd530
`define RSPB_SD4_STEP_MV    12'd10
`define RSPB_LR_BASE_MV     12'd900
`define RSPB_LR_STEP_MV     12'd50

`endif

// ===== verilog/rspb_conv_sel.v
/*
  one step-down converter: picks the active setpoint, decodes the
  effective run mode and scales the level code to millivolts.
  assumes the parent registers every output.
*/
`timescale 1ns/1ps
`include "rspb_defines.vh"

module rspb_conv_sel #(
  parameter [11:0] BASE_MV = 12'd300,
  parameter [11:0] STEP_MV = 12'd10
) (
  sel_b,
  set_a,
  set_b,
  op_mode,
  level,
  millivolt,
  run_mode
);
  input  wire        sel_b;
  input  wire [7:0]  set_a;
  input  wire [7:0]  set_b;
  input  wire [1:0]  op_mode;
  output wire [6:0]  level;
  output wire [11:0] millivolt;
  output reg  [1:0]  run_mode;

  wire [7:0] act = sel_b ? set_b : set_a;

  assign level     = act[`RSPB_SD_LVL_MSB:0];
  assign millivolt = BASE_MV + {5'h00, level} * STEP_MV; // R4 R5 R6

  always @* begin
    case (op_mode) // R11
      `RSPB_MODE_BY_SEL:
        run_mode = act[`RSPB_SLEEP_BIT] ? `RSPB_MODE_PFM : `RSPB_MODE_PWM; // R1 R2 R3
      `RSPB_MODE_PFM:  run_mode = `RSPB_MODE_PFM;
      `RSPB_MODE_PWM:  run_mode = `RSPB_MODE_PWM;
      default:         run_mode = `RSPB_MODE_AUTO;
    endcase
  end
endmodule // rspb_conv_sel

// ===== verilog/rspb_ldo_sel.v
/*
  one linear regulator: picks the active setpoint, clamps the code to
  the usable range and derives the sleep request.
  assumes the parent registers every output.
*/
`timescale 1ns/1ps
`include "rspb_defines.vh"

module rspb_ldo_sel (
  input  wire        sel_b,
  input  wire [7:0]  set_a,
  input  wire [7:0]  set_b,
  output wire [5:0]  level,
  output wire [11:0] millivolt,
  output wire        sleep
);
  function [5:0] clamp_code;
    input [5:0] c;
    begin
      if (c < `RSPB_LR_CODE_MIN)
        clamp_code = `RSPB_LR_CODE_MIN;
      else if (c > `RSPB_LR_CODE_MAX)
        clamp_code = `RSPB_LR_CODE_MAX;
      else
        clamp_code = c;
    end
  endfunction

  wire [7:0] act = sel_b ? set_b : set_a;

  assign level     = clamp_code(act[`RSPB_LR_LVL_MSB:0]); // R7 R8
  assign millivolt = `RSPB_LR_BASE_MV
                   + {6'h00, level - `RSPB_LR_CODE_MIN} * `RSPB_LR_STEP_MV;
  assign sleep     = act[`RSPB_SLEEP_BIT]; // R9 R10
endmodule // rspb_ldo_sel

// ===== verilog/rspb_bank.v
/*
  regulator setpoint bank: 8-bit read/write setpoint registers for four
  step-down converters and four linear regulators, with per-regulator
  a/b selection, mode decode and level clamping.
  assumes a synchronous register port on clk_sys; a/b selects, mode
  fields and the setpoints held elsewhere come from logic on clk_sys.
*/
`timescale 1ns/1ps
`include "rspb_defines.vh"

// Function
// R1 - converter sleep bit 0 with a: pwm
// R2 - converter sleep bit 1 with b: pfm
// R3 - sleep bits count only in mode zero
// R4 - converter 3 levels: 0.80 V, 20 mV steps
// R5 - converters 1,2 levels: 0.3 V, 10 mV
// R6 - converter 4 level: 0.53 V, 10 mV
// R7 - linear levels 6 bits, 0.90-3.60 V
// R8 - linear codes clamped to 0x02..0x38
// R9 - linear bit 7 sleeps when a selected
// R10 - linear bit 7 sleeps when b selected
// R11 - mode field: sel, pfm, pwm, auto
// R12 - selected setpoint drives regulator outputs
// R13 - every register bit stored and read back
module rspb_bank (
  input  wire                    clk_sys,
  input  wire                    reset_n,
  input  wire [`RSPB_ADDR_W-1:0] reg_addr,
  input  wire                    reg_wr_en,
  input  wire                    reg_rd_en,
  input  wire [7:0]              reg_wdata,
  output reg  [7:0]              reg_rdata_q,
  input  wire                    sd1_sel_b,
  input  wire                    sd2_sel_b,
  input  wire                    sd3_sel_b,
  input  wire                    sd4_sel_b,
  input  wire                    lr1_sel_b,
  input  wire                    lr2_sel_b,
  input  wire                    lr3_sel_b,
  input  wire                    lr4_sel_b,
  input  wire [1:0]              step_down1_op_mode,
  input  wire [1:0]              step_down2_op_mode,
  input  wire [1:0]              step_down3_op_mode,
  input  wire [1:0]              step_down4_op_mode,
  input  wire [7:0]              step_down1_level_a,
  input  wire [7:0]              step_down2_level_a,
  input  wire [7:0]              step_down4_level_a,
  input  wire [7:0]              linreg4_level_b,
  output reg  [6:0]              sd1_lvl_q,
  output reg  [6:0]              sd2_lvl_q,
  output reg  [6:0]              sd3_lvl_q,
  output reg  [6:0]              sd4_lvl_q,
  output reg  [11:0]             sd1_mv_q,
  output reg  [11:0]             sd2_mv_q,
  output reg  [11:0]             sd3_mv_q,
  output reg  [11:0]             sd4_mv_q,
  output reg  [1:0]              sd1_mode_q,
  output reg  [1:0]              sd2_mode_q,
  output reg  [1:0]              sd3_mode_q,
  output reg  [1:0]              sd4_mode_q,
  output reg  [5:0]              lr1_lvl_q,
  output reg  [5:0]              lr2_lvl_q,
  output reg  [5:0]              lr3_lvl_q,
  output reg  [5:0]              lr4_lvl_q,
  output reg  [11:0]             lr1_mv_q,
  output reg  [11:0]             lr2_mv_q,
  output reg  [11:0]             lr3_mv_q,
  output reg  [11:0]             lr4_mv_q,
  output reg                     lr1_sleep_q,
  output reg                     lr2_sleep_q,
  output reg                     lr3_sleep_q,
  output reg                     lr4_sleep_q
);

  // reset release synchroniser; assertion stays asynchronous
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n = rst_s2_q;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // setpoint registers, all eight bits kept including bit 6, unused by the linear regulators
  reg [7:0] step_down3_level_a_q;
  reg [7:0] linreg1_level_a_q;
  reg [7:0] linreg2_level_a_q;
  reg [7:0] linreg3_level_a_q;
  reg [7:0] linreg4_level_a_q;
  reg [7:0] step_down2_level_b_q;
  reg [7:0] step_down1_level_b_q;
  reg [7:0] step_down4_level_b_q;
  reg [7:0] step_down3_level_b_q;
  reg [7:0] linreg1_level_b_q;
  reg [7:0] linreg2_level_b_q;
  reg [7:0] linreg3_level_b_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_down3_level_a_q <= `RSPB_REG_RESET;
      linreg1_level_a_q    <= `RSPB_REG_RESET;
      linreg2_level_a_q    <= `RSPB_REG_RESET;
      linreg3_level_a_q    <= `RSPB_REG_RESET;
      linreg4_level_a_q    <= `RSPB_REG_RESET;
      step_down2_level_b_q <= `RSPB_REG_RESET;
      step_down1_level_b_q <= `RSPB_REG_RESET;
      step_down4_level_b_q <= `RSPB_REG_RESET;
      step_down3_level_b_q <= `RSPB_REG_RESET;
      linreg1_level_b_q    <= `RSPB_REG_RESET;
      linreg2_level_b_q    <= `RSPB_REG_RESET;
      linreg3_level_b_q    <= `RSPB_REG_RESET;
    end else if (reg_wr_en) begin
      // writes to unmapped offsets are dropped silently
      if (reg_addr == `RSPB_OFF_SD3_A)
        step_down3_level_a_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR1_A)
        linreg1_level_a_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR2_A)
        linreg2_level_a_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR3_A)
        linreg3_level_a_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR4_A)
        linreg4_level_a_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_SD2_B)
        step_down2_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_SD1_B)
        step_down1_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_SD4_B)
        step_down4_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_SD3_B)
        step_down3_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR1_B)
        linreg1_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR2_B)
        linreg2_level_b_q <= reg_wdata; // R13
      else if (reg_addr == `RSPB_OFF_LR3_B)
        linreg3_level_b_q <= reg_wdata; // R13
    end
  end

  // read path: one cycle latency, stored value returned unchanged
  reg [7:0] rdata_d;

  always @* begin
    if (reg_addr == `RSPB_OFF_SD3_A)
      rdata_d = step_down3_level_a_q; // R13
    else if (reg_addr == `RSPB_OFF_LR1_A)
      rdata_d = linreg1_level_a_q;
    else if (reg_addr == `RSPB_OFF_LR2_A)
      rdata_d = linreg2_level_a_q;
    else if (reg_addr == `RSPB_OFF_LR3_A)
      rdata_d = linreg3_level_a_q;
    else if (reg_addr == `RSPB_OFF_LR4_A)
      rdata_d = linreg4_level_a_q;
    else if (reg_addr == `RSPB_OFF_SD2_B)
      rdata_d = step_down2_level_b_q;
    else if (reg_addr == `RSPB_OFF_SD1_B)
      rdata_d = step_down1_level_b_q;
    else if (reg_addr == `RSPB_OFF_SD4_B)
      rdata_d = step_down4_level_b_q;
    else if (reg_addr == `RSPB_OFF_SD3_B)
      rdata_d = step_down3_level_b_q;
    else if (reg_addr == `RSPB_OFF_LR1_B)
      rdata_d = linreg1_level_b_q;
    else if (reg_addr == `RSPB_OFF_LR2_B)
      rdata_d = linreg2_level_b_q;
    else if (reg_addr == `RSPB_OFF_LR3_B)
      rdata_d = linreg3_level_b_q;
    else
      rdata_d = `RSPB_RDATA_UNMAPPED;
  end

  // read data holds until the next read so slow masters can sample it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      reg_rdata_q <= `RSPB_RDATA_UNMAPPED;
    else if (reg_rd_en)
      reg_rdata_q <= rdata_d;
  end

  // converter selection and decode
  wire [6:0]  sd1_lvl_d, sd2_lvl_d, sd3_lvl_d, sd4_lvl_d;
  wire [11:0] sd1_mv_d, sd2_mv_d, sd3_mv_d, sd4_mv_d;
  wire [1:0]  sd1_mode_d, sd2_mode_d, sd3_mode_d, sd4_mode_d;

  // R1 R2 R3 R11 inside each instance; R5 scaling
  rspb_conv_sel #(
    .BASE_MV (`RSPB_SD12_BASE_MV),
    .STEP_MV (`RSPB_SD12_STEP_MV)
  ) u_sd1 (
    .sel_b     (sd1_sel_b),
    .set_a     (step_down1_level_a),
    .set_b     (step_down1_level_b_q),
    .op_mode   (step_down1_op_mode),
    .level     (sd1_lvl_d),
    .millivolt (sd1_mv_d),
    .run_mode  (sd1_mode_d)
  );

  // R5
  rspb_conv_sel #(
    .BASE_MV (`RSPB_SD12_BASE_MV),
    .STEP_MV (`RSPB_SD12_STEP_MV)
  ) u_sd2 (
    .sel_b     (sd2_sel_b),
    .set_a     (step_down2_level_a),
    .set_b     (step_down2_level_b_q),
    .op_mode   (step_down2_op_mode),
    .level     (sd2_lvl_d),
    .millivolt (sd2_mv_d),
    .run_mode  (sd2_mode_d)
  );

  // R4
  rspb_conv_sel #(
    .BASE_MV (`RSPB_SD3_BASE_MV),
    .STEP_MV (`RSPB_SD3_STEP_MV)
  ) u_sd3 (
    .sel_b     (sd3_sel_b),
    .set_a     (step_down3_level_a_q),
    .set_b     (step_down3_level_b_q),
    .op_mode   (step_down3_op_mode),
    .level     (sd3_lvl_d),
    .millivolt (sd3_mv_d),
    .run_mode  (sd3_mode_d)
  );

  // R6
  rspb_conv_sel #(
    .BASE_MV (`RSPB_SD4_BASE_MV),
    .STEP_MV (`RSPB_SD4_STEP_MV)
  ) u_sd4 (
    .sel_b     (sd4_sel_b),
    .set_a     (step_down4_level_a),
    .set_b     (step_down4_level_b_q),
    .op_mode   (step_down4_op_mode),
    .level     (sd4_lvl_d),
    .millivolt (sd4_mv_d),
    .run_mode  (sd4_mode_d)
  );

  // linear regulator selection, clamp and sleep: R7 R8 R9 R10
  wire [5:0]  lr1_lvl_d, lr2_lvl_d, lr3_lvl_d, lr4_lvl_d;
  wire [11:0] lr1_mv_d, lr2_mv_d, lr3_mv_d, lr4_mv_d;
  wire        lr1_sleep_d, lr2_sleep_d, lr3_sleep_d, lr4_sleep_d;

  rspb_ldo_sel u_lr1 (
    .sel_b     (lr1_sel_b),
    .set_a     (linreg1_level_a_q),
    .set_b     (linreg1_level_b_q),
    .level     (lr1_lvl_d),
    .millivolt (lr1_mv_d),
    .sleep     (lr1_sleep_d)
  );

  rspb_ldo_sel u_lr2 (
    .sel_b     (lr2_sel_b),
    .set_a     (linreg2_level_a_q),
    .set_b     (linreg2_level_b_q),
    .level     (lr2_lvl_d),
    .millivolt (lr2_mv_d),
    .sleep     (lr2_sleep_d)
  );

  rspb_ldo_sel u_lr3 (
    .sel_b     (lr3_sel_b),
    .set_a     (linreg3_level_a_q),
    .set_b     (linreg3_level_b_q),
    .level     (lr3_lvl_d),
    .millivolt (lr3_mv_d),
    .sleep     (lr3_sleep_d)
  );

  // the b setpoint of regulator 4 lives outside this bank
  rspb_ldo_sel u_lr4 (
    .sel_b     (lr4_sel_b),
    .set_a     (linreg4_level_a_q),
    .set_b     (linreg4_level_b),
    .level     (lr4_lvl_d),
    .millivolt (lr4_mv_d),
    .sleep     (lr4_sleep_d)
  );

  // regulator control outputs, registered so the analog side sees
  // glitch-free levels; costs one cycle after any select change
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sd1_lvl_q   <= 7'h00;
      sd2_lvl_q   <= 7'h00;
      sd3_lvl_q   <= 7'h00;
      sd4_lvl_q   <= 7'h00;
      sd1_mv_q    <= `RSPB_SD12_BASE_MV;
      sd2_mv_q    <= `RSPB_SD12_BASE_MV;
      sd3_mv_q    <= `RSPB_SD3_BASE_MV;
      sd4_mv_q    <= `RSPB_SD4_BASE_MV;
      sd1_mode_q  <= `RSPB_MODE_PWM;
      sd2_mode_q  <= `RSPB_MODE_PWM;
      sd3_mode_q  <= `RSPB_MODE_PWM;
      sd4_mode_q  <= `RSPB_MODE_PWM;
      lr1_lvl_q   <= `RSPB_LR_CODE_MIN;
      lr2_lvl_q   <= `RSPB_LR_CODE_MIN;
      lr3_lvl_q   <= `RSPB_LR_CODE_MIN;
      lr4_lvl_q   <= `RSPB_LR_CODE_MIN;
      lr1_mv_q    <= `RSPB_LR_BASE_MV;
      lr2_mv_q    <= `RSPB_LR_BASE_MV;
      lr3_mv_q    <= `RSPB_LR_BASE_MV;
      lr4_mv_q    <= `RSPB_LR_BASE_MV;
      lr1_sleep_q <= 1'b0;
      lr2_sleep_q <= 1'b0;
      lr3_sleep_q <= 1'b0;
      lr4_sleep_q <= 1'b0;
    end else begin
      sd1_lvl_q   <= sd1_lvl_d; // R12
      sd2_lvl_q   <= sd2_lvl_d;
      sd3_lvl_q   <= sd3_lvl_d;
      sd4_lvl_q   <= sd4_lvl_d;
      sd1_mv_q    <= sd1_mv_d;
      sd2_mv_q    <= sd2_mv_d;
      sd3_mv_q    <= sd3_mv_d;
      sd4_mv_q    <= sd4_mv_d;
      sd1_mode_q  <= sd1_mode_d; // R12
      sd2_mode_q  <= sd2_mode_d;
      sd3_mode_q  <= sd3_mode_d;
      sd4_mode_q  <= sd4_mode_d;
      lr1_lvl_q   <= lr1_lvl_d; // R12
      lr2_lvl_q   <= lr2_lvl_d;
      lr3_lvl_q   <= lr3_lvl_d;
      lr4_lvl_q   <= lr4_lvl_d;
      lr1_mv_q    <= lr1_mv_d;
      lr2_mv_q    <= lr2_mv_d;
      lr3_mv_q    <= lr3_mv_d;
      lr4_mv_q    <= lr4_mv_d;
      lr1_sleep_q <= lr1_sleep_d; // R12
      lr2_sleep_q <= lr2_sleep_d;
      lr3_sleep_q <= lr3_sleep_d;
      lr4_sleep_q <= lr4_sleep_d;
    end
  end

endmodule // rspb_bank

// ===== verification/rspb_bank_assertions.sv
/*
  checker of the setpoint bank: read path, converter mode and level
  selection, level scaling and linear-regulator clamping.
  assumes it is bound to rspb_bank and sees only its ports.
*/
`timescale 1ns/1ps

module rspb_bank_assertions (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [8:0]  reg_addr,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        sd1_sel_b,
  input wire logic [1:0]  step_down1_op_mode,
  input wire logic [7:0]  step_down1_level_a,
  input wire logic [6:0]  sd1_lvl_q,
  input wire logic [11:0] sd1_mv_q,
  input wire logic [1:0]  sd1_mode_q,
  input wire logic [6:0]  sd3_lvl_q,
  input wire logic [11:0] sd3_mv_q,
  input wire logic [6:0]  sd4_lvl_q,
  input wire logic [11:0] sd4_mv_q,
  input wire logic [5:0]  lr1_lvl_q,
  input wire logic [11:0] lr1_mv_q,
  input wire logic        lr4_sel_b,
  input wire logic [7:0]  linreg4_level_b,
  input wire logic [5:0]  lr4_lvl_q,
  input wire logic        lr4_sleep_q
);
  // outputs lag the pin release by the internal reset synchroniser
  logic [1:0] rel_q;
  wire        ready = (rel_q == 2'h3);
  wire  [5:0] lr4_clamp = (linreg4_level_b[5:0] < 6'h02) ? 6'h02 :
                          ((linreg4_level_b[5:0] > 6'h38) ? 6'h38 : linreg4_level_b[5:0]);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rel_q <= 2'h0;
    end else if (rel_q != 2'h3) begin
      rel_q <= rel_q + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_a_mode0;
    ready && !sd1_sel_b && step_down1_op_mode == 2'h0;
  endsequence

  a_rd_unmapped: assert property (ready && reg_rd_en && reg_addr < 9'h0A7 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_rd_holds: assert property (!reg_rd_en |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  a_mode_fwd: assert property (ready && step_down1_op_mode != 2'h0 |=> sd1_mode_q == $past(step_down1_op_mode))
    else $error("forced mode not passed through");
  a_sleep_pwm: assert property (s_a_mode0 ##0 !step_down1_level_a[7] |=> sd1_mode_q == 2'h2)
    else $error("sleep bit 0 did not give pwm");
  a_sleep_pfm: assert property (s_a_mode0 ##0 step_down1_level_a[7] |=> sd1_mode_q == 2'h1)
    else $error("sleep bit 1 did not give pfm");
  a_lvl_sel_a: assert property (ready && !sd1_sel_b |=> sd1_lvl_q == $past(step_down1_level_a[6:0]))
    else $error("a level not selected");
  a_sd1_scale: assert property (sd1_mv_q == 12'd300 + 12'd10 * {5'h0, sd1_lvl_q})
    else $error("converter 1 scaling wrong");
  a_sd3_scale: assert property (sd3_mv_q == 12'd800 + 12'd20 * {5'h0, sd3_lvl_q})
    else $error("converter 3 scaling wrong");
  a_sd4_scale: assert property (sd4_mv_q == 12'd530 + 12'd10 * {5'h0, sd4_lvl_q})
    else $error("converter 4 scaling wrong");
  a_lr_scale: assert property (lr1_mv_q == 12'd900 + 12'd50 * {6'h0, lr1_lvl_q - 6'h02})
    else $error("linear scaling wrong");
  a_lr4_clamp: assert property (ready && lr4_sel_b |=> lr4_lvl_q == $past(lr4_clamp))
    else $error("linear code not clamped");
  a_lr4_sleep: assert property (ready && lr4_sel_b |=> lr4_sleep_q == $past(linreg4_level_b[7]))
    else $error("b sleep bit not followed");
endmodule // rspb_bank_assertions

bind rspb_bank rspb_bank_assertions u_rspb_bank_assertions (.clk_sys, .reset_n, .reg_addr,
  .reg_rd_en, .reg_rdata_q, .sd1_sel_b, .step_down1_op_mode, .step_down1_level_a, .sd1_lvl_q,
  .sd1_mv_q, .sd1_mode_q, .sd3_lvl_q, .sd3_mv_q, .sd4_lvl_q, .sd4_mv_q, .lr1_lvl_q, .lr1_mv_q,
  .lr4_sel_b, .linreg4_level_b, .lr4_lvl_q, .lr4_sleep_q);

// ===== verification/rspb_bank_test.sv
/*
  self-checking bench of the setpoint bank: register port, a/b
  selection, mode decode, scaling and clamping.
  assumes rspb_bank and its checker are compiled before it.
*/
`timescale 1ns/1ps
`include "rspb_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module rspb_bank_test;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        sd_sel_b = 1'b0;
  logic        lr_sel_b = 1'b0;
  logic [1:0]  op_mode = 2'h0;
  logic [7:0]  step_down1_level_a = 8'h00;
  logic [7:0]  step_down2_level_a = 8'h00;
  logic [7:0]  step_down4_level_a = 8'h7F;
  logic [7:0]  linreg4_level_b = 8'h00;
  logic [7:0]  reg_rdata_q;
  logic [6:0]  sd1_lvl_q, sd2_lvl_q, sd3_lvl_q;
  logic [11:0] sd2_mv_q, sd3_mv_q, sd4_mv_q, lr1_mv_q, lr2_mv_q, lr3_mv_q, lr4_mv_q;
  logic [1:0]  sd2_mode_q, sd3_mode_q, sd4_mode_q;
  logic [5:0]  lr1_lvl_q, lr2_lvl_q, lr3_lvl_q, c_v;
  logic        lr1_sleep_q, lr2_sleep_q, lr3_sleep_q;
  int          err_count = 0;
  int          tests_run = 0;
  int unsigned seed_v;
  logic [7:0]  exp_q[$];
  logic [7:0]  shadow[12];
  logic [7:0]  a_v, b_v, s_v, e_v;
  logic [8:0]  offs[12] = '{`RSPB_OFF_SD3_A, `RSPB_OFF_LR1_A, `RSPB_OFF_LR2_A, `RSPB_OFF_LR3_A,
    `RSPB_OFF_LR4_A, `RSPB_OFF_SD2_B, `RSPB_OFF_SD1_B, `RSPB_OFF_SD4_B, `RSPB_OFF_SD3_B,
    `RSPB_OFF_LR1_B, `RSPB_OFF_LR2_B, `RSPB_OFF_LR3_B};
  logic [5:0]  codes[6] = '{6'h00, 6'h01, 6'h02, 6'h38, 6'h39, 6'h3F};

  rspb_bank u_rspb_bank (.clk_sys, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata_q, .sd1_sel_b(sd_sel_b), .sd2_sel_b(sd_sel_b), .sd3_sel_b(sd_sel_b),
    .sd4_sel_b(sd_sel_b), .lr1_sel_b(lr_sel_b), .lr2_sel_b(lr_sel_b), .lr3_sel_b(lr_sel_b),
    .lr4_sel_b(lr_sel_b), .step_down1_op_mode(op_mode), .step_down2_op_mode(op_mode),
    .step_down3_op_mode(op_mode), .step_down4_op_mode(op_mode), .step_down1_level_a,
    .step_down2_level_a, .step_down4_level_a, .linreg4_level_b, .sd1_lvl_q, .sd2_lvl_q,
    .sd3_lvl_q, .sd4_lvl_q(), .sd1_mv_q(), .sd2_mv_q, .sd3_mv_q, .sd4_mv_q, .sd1_mode_q(),
    .sd2_mode_q, .sd3_mode_q, .sd4_mode_q, .lr1_lvl_q, .lr2_lvl_q, .lr3_lvl_q,
    .lr4_lvl_q(), .lr1_mv_q, .lr2_mv_q, .lr3_mv_q, .lr4_mv_q, .lr1_sleep_q,
    .lr2_sleep_q, .lr3_sleep_q, .lr4_sleep_q());

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // strobes stay up between calls so back-to-back accesses need no idle cycle
  task automatic acc(input logic wr, input logic rd, input logic [8:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    @(negedge clk_sys);
    reg_wr_en = wr;
    reg_rd_en = rd;
    reg_addr = a;
    reg_wdata = d;
    if (rd) exp_q.push_back(e);
  endtask

  function automatic logic [5:0] clamp(input logic [5:0] c);
    return (c < 6'h02) ? 6'h02 : ((c > 6'h38) ? 6'h38 : c);
  endfunction

  function automatic logic [11:0] lr_mv(input logic [5:0] c);
    return 12'd900 + 12'd50 * {6'h00, clamp(c) - 6'h02};
  endfunction

  // forced modes pass through; mode zero follows the active sleep bit
  function automatic logic [1:0] eff_mode(input logic [1:0] md, input logic sl);
    return (md != 2'h0) ? md : (sl ? 2'h1 : 2'h2);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (reg_rd_en === 1'b1) begin
      #1;
      e_v = exp_q.pop_front();
      `CHK(reg_rdata_q, e_v)
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    tally_and_finish;
  end

  initial begin
    seed_v = $urandom(8);
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // write and read together: the read sees the reset value
    foreach (offs[i]) begin
      shadow[i] = 8'($urandom);
      acc(1'b1, 1'b1, offs[i], shadow[i], 8'h00);
    end
    foreach (offs[i]) acc(1'b0, 1'b1, offs[i], 8'h00, shadow[i]);
    acc(1'b1, 1'b0, 9'h0A8, 8'hFF, 8'h00);
    acc(1'b0, 1'b1, 9'h0A8, 8'h00, 8'h00);
    acc(1'b0, 1'b1, 9'h000, 8'h00, 8'h00);
    for (int r = 0; r < 2; r++) begin
      a_v = {r[0], 7'($urandom)};
      b_v = {~r[0], 7'h7F};
      acc(1'b1, 1'b0, `RSPB_OFF_SD3_A, a_v, 8'h00);
      acc(1'b1, 1'b0, `RSPB_OFF_SD3_B, b_v, 8'h00);
      acc(1'b1, 1'b0, `RSPB_OFF_SD2_B, 8'h7F, 8'h00);
      acc(1'b0, 1'b0, 9'h000, 8'h00, 8'h00);
      for (int m = 0; m < 8; m++) begin
        @(negedge clk_sys);
        op_mode = m[2:1];
        sd_sel_b = m[0];
        step_down1_level_a = 8'($urandom);
        step_down2_level_a = 8'($urandom);
        repeat (2) @(negedge clk_sys);
        s_v = m[0] ? b_v : a_v;
        `CHK(sd3_lvl_q, s_v[6:0])
        `CHK(sd3_mv_q, 12'd800 + 12'd20 * {5'h0, s_v[6:0]})
        `CHK(sd3_mode_q, (op_mode != 2'h0) ? op_mode : (s_v[7] ? 2'h1 : 2'h2))
        `CHK(sd2_mv_q, m[0] ? 12'd1570 : 12'd300 + 12'd10 * {5'h0, step_down2_level_a[6:0]})
        `CHK(sd4_mv_q, m[0] ? 12'd530 + 12'd10 * {5'h0, shadow[7][6:0]} : 12'd1800)
        `CHK(sd1_lvl_q, m[0] ? shadow[6][6:0] : step_down1_level_a[6:0])
        `CHK(sd2_lvl_q, m[0] ? 7'h7F : step_down2_level_a[6:0])
        `CHK(sd2_mode_q, eff_mode(op_mode, m[0] ? 1'b0 : step_down2_level_a[7]))
        `CHK(sd4_mode_q, eff_mode(op_mode, m[0] ? shadow[7][7] : 1'b0))
      end
    end
    foreach (codes[i]) begin
      a_v = {i[0], 1'b1, codes[i]};
      b_v = {~i[0], 1'b0, ~codes[i]};
      linreg4_level_b = {i[0], 1'b0, codes[i]};
      acc(1'b1, 1'b0, `RSPB_OFF_LR1_A, a_v, 8'h00);
      // same-cycle read returns the value held before this write
      acc(1'b1, 1'b1, `RSPB_OFF_LR1_B, b_v, shadow[9]);
      shadow[9] = b_v;
      acc(1'b0, 1'b0, 9'h000, 8'h00, 8'h00);
      for (int s = 0; s < 2; s++) begin
        @(negedge clk_sys);
        lr_sel_b = s[0];
        repeat (2) @(negedge clk_sys);
        s_v = s[0] ? b_v : a_v;
        c_v = clamp(s_v[5:0]);
        `CHK(lr1_lvl_q, c_v)
        `CHK(lr1_mv_q, 12'd900 + 12'd50 * {6'h0, c_v - 6'h02})
        `CHK(lr1_sleep_q, s_v[7])
        `CHK(lr2_lvl_q, clamp(s[0] ? shadow[10][5:0] : shadow[2][5:0]))
        `CHK(lr2_mv_q, lr_mv(s[0] ? shadow[10][5:0] : shadow[2][5:0]))
        `CHK(lr2_sleep_q, s[0] ? shadow[10][7] : shadow[2][7])
        `CHK(lr3_lvl_q, clamp(s[0] ? shadow[11][5:0] : shadow[3][5:0]))
        `CHK(lr3_mv_q, lr_mv(s[0] ? shadow[11][5:0] : shadow[3][5:0]))
        `CHK(lr3_sleep_q, s[0] ? shadow[11][7] : shadow[3][7])
        `CHK(lr4_mv_q, lr_mv(s[0] ? linreg4_level_b[5:0] : shadow[4][5:0]))
      end
    end
    tally_and_finish;
  end
endmodule // rspb_bank_test
